// [logic/fscw_defs.vh]
`ifndef FSCW_DEFS_VH
`define FSCW_DEFS_VH

// synchroniser depth
`define FSCW_SYNC_STAGES 2
// pwm period in system clocks
`define FSCW_PWM_PERIOD 8'h64
// full drive duty
`define FSCW_DUTY_FULL 8'h64
// reset duty
`define FSCW_DUTY_RST 8'h32
// tolerance in percent
`define FSCW_TOL_PCT 8'h02
// percent scale
`define FSCW_PCT_SCALE 8'h64

`endif

// [logic/fscw_channel.v]
`timescale 1ns/100ps
`include "fscw_defs.vh"

module fscw_channel #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // measurement inputs, already synchronised
    input wire tach_s,
    input wire ref_s,
    // control
    input wire [CNT_W-1:0] target_cnt,
    input wire force_full,
    // results
    output reg [CNT_W-1:0] speed_q,
    output reg pwm_q,
    output reg in_band_q,
    output reg stalled_q
);

// --------------------------------------------------------------
// speed measurement
// --------------------------------------------------------------
// speed is the number of reference edges per tach period: larger = slower
reg tach_d1_q;
reg ref_d1_q;
reg [CNT_W-1:0] ref_cnt_q;
reg upd_q;
wire tach_rise = tach_s & ~tach_d1_q;
wire ref_rise = ref_s & ~ref_d1_q;
wire cnt_max = &ref_cnt_q;

always @(posedge clk_sys) begin
    if (!rst_n) begin
        tach_d1_q <= 1'b0;
        ref_d1_q <= 1'b0;
        ref_cnt_q <= {CNT_W{1'b0}};
        speed_q <= {CNT_W{1'b1}};
        upd_q <= 1'b0;
        stalled_q <= 1'b0;
    end else begin
        tach_d1_q <= tach_s;
        ref_d1_q <= ref_s;
        upd_q <= 1'b0;
        if (tach_rise) begin
            speed_q <= ref_cnt_q;
            ref_cnt_q <= {CNT_W{1'b0}};
            upd_q <= 1'b1;
            stalled_q <= 1'b0;
        end else if (ref_rise && !cnt_max) begin
            ref_cnt_q <= ref_cnt_q + 1'b1;
        end else if (ref_rise) begin
            // saturated: fan stopped, report slowest and push drive up
            speed_q <= {CNT_W{1'b1}};
            stalled_q <= 1'b1;
            upd_q <= 1'b1;
        end
    end
end

// --------------------------------------------------------------
// regulation loop and pwm
// --------------------------------------------------------------
reg [7:0] duty_q;
reg [7:0] phase_q;
wire [CNT_W+7:0] err_scaled;
wire [CNT_W+7:0] tol_band;
wire too_slow = speed_q > target_cnt;
wire [CNT_W-1:0] diff = too_slow ? (speed_q - target_cnt) : (target_cnt - speed_q);
assign err_scaled = {8'h00, diff} * {{CNT_W{1'b0}}, `FSCW_PCT_SCALE};
assign tol_band = {8'h00, target_cnt} * {{CNT_W{1'b0}}, `FSCW_TOL_PCT};
wire in_band = err_scaled <= tol_band;

always @(posedge clk_sys) begin
    if (!rst_n) begin
        duty_q <= `FSCW_DUTY_RST;
        phase_q <= 8'h00;
        pwm_q <= 1'b0;
        in_band_q <= 1'b0;
    end else begin
        phase_q <= (phase_q == `FSCW_PWM_PERIOD - 8'h01) ? 8'h00 : phase_q + 8'h01;
        // override only forces the pin; the loop keeps adjusting duty_q underneath
        pwm_q <= force_full ? 1'b1 : (phase_q < duty_q);
        if (upd_q) begin
            in_band_q <= in_band;
            if (!in_band && too_slow && duty_q != `FSCW_DUTY_FULL) begin
                duty_q <= duty_q + 8'h01;
            end else if (!in_band && !too_slow && duty_q != 8'h00) begin
                duty_q <= duty_q - 8'h01;
            end
        end
    end
end

endmodule

// [logic/fscw_top.v]
`timescale 1ns/100ps
`include "fscw_defs.vh"

module fscw_top #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // fan pins
    input wire tach0,
    input wire tach1,
    input wire ref_clk_in,
    output wire fan_drv0,
    output wire fan_drv1,
    // thermometer results, same clock
    input wire [7:0] temp_r0,
    input wire [7:0] temp_r1,
    input wire [7:0] tmax_r0,
    input wire [7:0] tmax_r1,
    input wire open_r0,
    input wire open_r1,
    input wire short_r0,
    input wire short_r1,
    // register interface side (byte transactions decoded outside)
    input wire [CNT_W-1:0] target0,
    input wire [CNT_W-1:0] target1,
    output wire [CNT_W-1:0] speed0,
    output wire [CNT_W-1:0] speed1,
    output wire [3:0] fan_status,
    output reg override_q
);

// --------------------------------------------------------------
// pin synchronisers
// --------------------------------------------------------------
reg [2:0] sync1_q;
reg [2:0] sync2_q;
always @(posedge clk_sys) begin
    if (!rst_n) begin
        sync1_q <= 3'h0;
        sync2_q <= 3'h0;
    end else begin
        sync1_q <= {ref_clk_in, tach1, tach0};
        sync2_q <= sync1_q;
    end
end

// --------------------------------------------------------------
// watchdog
// --------------------------------------------------------------
// signed compare: values are two's complement degrees
wire hot0 = $signed(temp_r0) > $signed(tmax_r0);
wire hot1 = $signed(temp_r1) > $signed(tmax_r1);
wire wd_cond = hot0 | hot1
    | open_r0 | open_r1
    | (short_r0 & short_r1);

always @(posedge clk_sys) begin
    if (!rst_n) begin
        override_q <= 1'b0;
    end else begin
        override_q <= wd_cond;
    end
end

// --------------------------------------------------------------
// channels
// --------------------------------------------------------------
wire [1:0] pwm;
wire [1:0] in_band;
wire [1:0] stalled;

// two instances, sharing only clock, reset, the override and the synchronised reference clock
fscw_channel #(.CNT_W(CNT_W)) u_ch0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tach_s(sync2_q[0]),
    .ref_s(sync2_q[2]),
    .target_cnt(target0),
    .force_full(override_q),
    .speed_q(speed0),
    .pwm_q(pwm[0]),
    .in_band_q(in_band[0]),
    .stalled_q(stalled[0])
);

fscw_channel #(.CNT_W(CNT_W)) u_ch1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tach_s(sync2_q[1]),
    .ref_s(sync2_q[2]),
    .target_cnt(target1),
    .force_full(override_q),
    .speed_q(speed1),
    .pwm_q(pwm[1]),
    .in_band_q(in_band[1]),
    .stalled_q(stalled[1])
);

assign fan_drv0 = pwm[0];
assign fan_drv1 = pwm[1];
assign fan_status = {stalled[1], in_band[1], stalled[0], in_band[0]};

endmodule

// [verif/fscw_fan_model.sv]
`timescale 1ns/100ps
module fscw_fan_model (
    // fan side
    output reg tach0,
    output reg tach1,
    output reg ref_clk_in
);
    // phases kept off the clk edges so the edge count per period is exact
    initial begin
        ref_clk_in = 1'b0;
        tach0 = 1'b0;
        tach1 = 1'b0;
        fork
            #10 forever #200 ref_clk_in = ~ref_clk_in;
            #30 forever #10000 tach0 = ~tach0;
            #30 forever #20000 tach1 = ~tach1;
        join
    end
endmodule

// [verif/fscw_top_properties.sv]
`timescale 1ns/100ps
module fscw_properties (
    // watched ports
    input wire clk_sys,
    input wire rst_n,
    input wire [7:0] temp_r0,
    input wire [7:0] temp_r1,
    input wire [7:0] tmax_r0,
    input wire [7:0] tmax_r1,
    input wire open_r0,
    input wire open_r1,
    input wire short_r0,
    input wire short_r1,
    input wire fan_drv0,
    input wire fan_drv1,
    input wire override_q
);
    wire hot0 = $signed(temp_r0) > $signed(tmax_r0);
    wire hot1 = $signed(temp_r1) > $signed(tmax_r1);
    wire cond = hot0 || hot1 || open_r0 || open_r1 || (short_r0 && short_r1);
    default clocking
        @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    hot_ch0_a: assert property (hot0 |=> override_q) else $error("hot0 ignored");
    hot_ch1_a: assert property (hot1 |=> override_q) else $error("hot1 ignored");
    open_ch0_a: assert property (open_r0 |=> override_q) else $error("open0");
    open_ch1_a: assert property (open_r1 |=> override_q) else $error("open1");
    short_both_a: assert property (short_r0 && short_r1 |=> override_q)
        else $error("short pair");
    short_one_a: assert property ((short_r0 ^ short_r1) && !hot0 && !hot1
        && !open_r0 && !open_r1 |=> !override_q) else $error("single short");
    clear_resume_a: assert property (!cond |=> !override_q) else $error("stuck");
    drive_full_a: assert property (override_q |=> fan_drv0 && fan_drv1)
        else $error("drive not full");
endmodule

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
    reg clk_sys, rst_n, open_r0, open_r1, short_r0, short_r1;
    reg [7:0] temp_r0, temp_r1, tmax_r0, tmax_r1;
    reg [15:0] target0, target1;
    reg [20:0] rows [0:8];
    wire [15:0] speed0, speed1;
    wire [3:0] fan_status;
    wire tach0, tach1, ref_clk_in, fan_drv0, fan_drv1, override_q;
    integer fail_count, tests_run, i, n;
    fscw_fan_model fscw_fan_model_inst (.*);
    fscw_top fscw_top_inst (.*);
    task check(input [15:0] got, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("Error t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        n = n + 1;
        if (n == 20000) begin
            fail_count = fail_count + 1;
            report_and_stop;
        end
    end
    initial begin
        n = 0;
        fail_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        {temp_r0, temp_r1, open_r1, open_r0, short_r1, short_r0} = 20'h0_0000;
        tmax_r0 = 8'h28;
        tmax_r1 = 8'h14;
        target0 = 16'h0032;
        target1 = 16'h0064;
        // temp0, temp1, open pair, short pair, override expected
        rows[0] = {8'h28, 8'h14, 2'h0, 2'h0, 1'b0};
        rows[1] = {8'h29, 8'h00, 2'h0, 2'h0, 1'b1};
        rows[2] = {8'h00, 8'h15, 2'h0, 2'h0, 1'b1};
        rows[3] = {8'hf0, 8'h00, 2'h0, 2'h0, 1'b0};
        rows[4] = {8'h80, 8'h80, 2'h0, 2'h0, 1'b0};
        rows[5] = {8'h00, 8'h00, 2'h1, 2'h0, 1'b1};
        rows[6] = {8'h00, 8'h00, 2'h2, 2'h0, 1'b1};
        rows[7] = {8'h00, 8'h00, 2'h0, 2'h1, 1'b0};
        rows[8] = {8'h00, 8'h00, 2'h0, 2'h3, 1'b1};
        repeat (12) @(posedge clk_sys);
        #1 check(speed0, 16'hffff);
        check(speed1, 16'hffff);
        check({fan_status, override_q, fan_drv0, fan_drv1}, 16'h0000);
        @(posedge clk_sys) rst_n <= 1'b1;
        repeat (1200) @(posedge clk_sys);
        #1 check(speed0, 16'h0032);
        check(speed1, 16'h0064);
        check(fan_status, 16'h0005);
        for (i = 0; i < 9; i = i + 1) begin
            @(posedge clk_sys);
            {temp_r0, temp_r1, open_r1, open_r0, short_r1, short_r0} <= rows[i][20:1];
            repeat (3) @(posedge clk_sys);
            #1 check(override_q, rows[i][0]);
            if (rows[i][0])
                check({fan_drv0, fan_drv1}, 16'h0003);
        end
        // the forced drive must give way, or pwm never gets back
        @(posedge clk_sys) {short_r1, short_r0} <= 2'h0;
        i = 0;
        repeat (150) begin
            @(posedge clk_sys);
            #1 if (!fan_drv0) i = i + 1;
        end
        check(override_q, 1'b0);
        check(i > 0, 1'b1);
        report_and_stop;
    end
endmodule
bind fscw_top fscw_properties fscw_properties_inst (.*);
